// ==== rtl/stx_pkg.sv ====
// shared constants for the serial transmitter
package stx_pkg;
    // register indices on the plain register port
    localparam logic [2:0] STX_ADDR_DATA = 3'h0;
    localparam logic [2:0] STX_ADDR_STAT_A = 3'h1;
    localparam logic [2:0] STX_ADDR_CTRL_B = 3'h2;
    localparam logic [2:0] STX_ADDR_CTRL_C = 3'h3;
    localparam logic [2:0] STX_ADDR_BAUD_LO = 3'h4;
    localparam logic [2:0] STX_ADDR_BAUD_HI = 3'h5;
    // status_reg_a fields
    localparam int STX_A_DOUBLE_SPEED = 1;
    localparam int STX_A_BUF_EMPTY = 5;
    localparam int STX_A_TX_COMPLETE = 6;
    // ctrl_reg_b fields
    localparam int STX_B_NINTH_BIT = 0;
    localparam int STX_B_SIZE_HI = 2;
    localparam int STX_B_TX_ENABLE = 3;
    localparam int STX_B_BUF_EMPTY_IE = 5;
    localparam int STX_B_TX_COMPLETE_IE = 6;
    // ctrl_reg_c fields
    localparam int STX_C_CLOCK_POL = 0;
    localparam int STX_C_SIZE_LO = 1;
    localparam int STX_C_STOP_BITS = 3;
    localparam int STX_C_PARITY_ODD = 4;
    localparam int STX_C_PARITY_EN = 5;
    localparam int STX_C_SYNC_MODE = 6;
    // reset values
    localparam logic [7:0] STX_RST_STAT_A = 8'h20;
    localparam logic [7:0] STX_RST_CTRL_B = 8'h00;
    localparam logic [7:0] STX_RST_CTRL_C = 8'h06;
    localparam logic [11:0] STX_RST_BAUD = 12'h000;
    // ticks per bit in asynchronous modes; size code 7 is nine bits
    localparam logic [4:0] STX_TICKS_NORMAL = 5'h10;
    localparam logic [4:0] STX_TICKS_DOUBLE = 5'h08;
    localparam logic [2:0] STX_SIZE_NINE = 3'h7;
endpackage

// ==== rtl/stx_bit_clock.sv ====
// bit-rate strobe generator: baud divider, master clock, slave sampling
`timescale 1ns/1ns
module stx_bit_clock
    import stx_pkg::*;
#(
    parameter int DIV_W = 12
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // configuration
    input wire logic [DIV_W-1:0] divisor_in,
    input wire logic double_speed_in,
    input wire logic sync_mode_in,
    input wire logic clock_polarity_in,
    input wire logic clk_master_in,
    input wire logic run_in,
    // external sync clock input (slave mode)
    input wire logic sync_clock_pin_in,
    // outputs
    output logic bit_strobe_out,
    output logic sync_clock_out
);
    logic [DIV_W-1:0] div_cnt_r;
    logic [4:0] tick_cnt_r;
    logic xck_meta_r;
    logic xck_sync_r;
    logic xck_prev_r;
    logic mclk_r;
    wire div_tick = (div_cnt_r == '0);
    wire [4:0] ticks_per_bit = double_speed_in ? STX_TICKS_DOUBLE
                                               : STX_TICKS_NORMAL;
    // data changes on rising edge for polarity 0, falling for 1
    wire ext_rise = xck_sync_r & ~xck_prev_r;
    wire ext_fall = ~xck_sync_r & xck_prev_r;
    wire ext_change = clock_polarity_in ? ext_fall : ext_rise;
    wire mclk_change = div_tick & (mclk_r == clock_polarity_in);
    wire async_strobe = div_tick && (tick_cnt_r == 5'h01);

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            div_cnt_r <= '0;
            tick_cnt_r <= STX_TICKS_NORMAL;
            xck_meta_r <= 1'b0;
            xck_sync_r <= 1'b0;
            xck_prev_r <= 1'b0;
            mclk_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_tick ? divisor_in : div_cnt_r - 1'b1;
            if (div_tick)
                tick_cnt_r <= (tick_cnt_r <= 5'h01) ? ticks_per_bit
                                                    : tick_cnt_r - 5'h01;
            xck_meta_r <= sync_clock_pin_in;
            xck_sync_r <= xck_meta_r;
            xck_prev_r <= xck_sync_r;
            // master clock idles at the level before a change edge
            if (!run_in)
                mclk_r <= clock_polarity_in;
            else if (div_tick)
                mclk_r <= ~mclk_r;
        end
    end

    assign bit_strobe_out = !sync_mode_in ? async_strobe :
                            clk_master_in ? (mclk_change & run_in) :
                            ext_change;
    assign sync_clock_out = mclk_r;
endmodule

// ==== rtl/stx_transmitter.sv ====
// transmit half of a serial port: registers, buffer, shifter, pins
//
// What this block does
// - While transmit enabled, drive the serial output pin from the transmitter.
// - In sync mode, transmitter owns the sync clock pin while enabled.
// - Data register write loads buffer and starts a transmission.
// - Buffer moves to shifter when idle or right after last stop bit.
// - A loaded shifter sends one frame at the selected bit rate.
// - Upper data bits beyond the character size are ignored.
// - Buffer-empty flag is one exactly while the buffer holds nothing.
// - Buffer-empty interrupt requested while flag set and enabled.
// - Writing the data register clears the buffer-empty flag.
// - Transmit-complete sets when frame done and buffer empty.
// - Transmit-complete clears on interrupt service or writing one.
// - Transmit-complete interrupt requested while flag set and enabled.
// - With parity enabled, parity bit goes between data and stop bits.
// - Clearing transmit enable waits until shifter and buffer are empty.
// - Once truly disabled, the output pin returns to port control.
// - Frame: low start, data LSB first, parity, high stops; idle high.
// - Parity is xor of data bits, inverted for odd.
// - Sync data changes on rising edge (pol 0) or falling (pol 1).
// - Async bit period is 16 divider ticks, 8 at double speed.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
module stx_transmitter
    import stx_pkg::*;
#(
    parameter int DIV_W = 12
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // interrupt requests and service
    output logic buffer_empty_irq_out,
    output logic tx_complete_irq_out,
    input wire logic tx_complete_ack_in,
    // serial output pin
    output logic serial_out,
    output logic serial_oe_out,
    // sync clock pin
    input wire logic sync_clock_pin_in,
    output logic sync_clock_pin_out,
    output logic sync_clock_pin_oe_out
);
    typedef enum logic [2:0] {
        STX_IDLE,
        STX_START,
        STX_DATA,
        STX_PARITY,
        STX_STOP
    } stx_state_t;

    stx_state_t state_r;
    stx_state_t state_nxt;
    logic [7:0] stat_a_r;
    logic [7:0] ctrl_b_r;
    logic [7:0] ctrl_c_r;
    logic [DIV_W-1:0] baud_r;
    logic [8:0] buf_data_r;
    logic buf_full_r;
    logic [8:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic parity_r;
    logic stop_cnt_r;
    logic tx_complete_r;
    logic active_r;
    logic line_r;
    logic [7:0] rdata_r;
    logic bit_strobe;
    logic sync_clk;

    // data bits for a size code: 5..8, code 7 is nine
    function automatic logic [3:0] char_bits(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h5;
        case (code)
            3'h0: n = 4'h5;
            3'h1: n = 4'h6;
            3'h2: n = 4'h7;
            3'h7: n = 4'h9;
            default: n = 4'h8;
        endcase
        return n;
    endfunction

    // zero bits beyond the character size
    function automatic logic [8:0] mask_char(input logic [8:0] d,
                                             input logic [3:0] n);
        logic [8:0] m;
        m = 9'h1FF >> (4'h9 - n);
        return d & m;
    endfunction

    wire [2:0] size_code = {ctrl_b_r[STX_B_SIZE_HI],
                            ctrl_c_r[STX_C_SIZE_LO+1 -: 2]};
    wire [3:0] nbits = char_bits(size_code);
    wire tx_enable = ctrl_b_r[STX_B_TX_ENABLE];
    wire parity_en = ctrl_c_r[STX_C_PARITY_EN];
    wire parity_odd = ctrl_c_r[STX_C_PARITY_ODD];
    wire two_stops = ctrl_c_r[STX_C_STOP_BITS];
    wire sync_mode = ctrl_c_r[STX_C_SYNC_MODE];
    wire double_speed = stat_a_r[STX_A_DOUBLE_SPEED] & ~sync_mode;
    wire wr_data = reg_write_in && (reg_addr_in == STX_ADDR_DATA);
    wire wr_stat = reg_write_in && (reg_addr_in == STX_ADDR_STAT_A);
    wire wr_ctrl_b = reg_write_in && (reg_addr_in == STX_ADDR_CTRL_B);
    wire wr_ctrl_c = reg_write_in && (reg_addr_in == STX_ADDR_CTRL_C);
    wire wr_baud_lo = reg_write_in && (reg_addr_in == STX_ADDR_BAUD_LO);
    wire wr_baud_hi = reg_write_in && (reg_addr_in == STX_ADDR_BAUD_HI);
    wire frame_last = bit_strobe && (state_r == STX_STOP) &&
                      (!two_stops || stop_cnt_r);
    wire shifter_idle = (state_r == STX_IDLE);
    // load when idle, or on the strobe that ends the last stop bit
    wire load_shift = buf_full_r && active_r &&
                      (frame_last || (shifter_idle && bit_strobe));
    wire frame_done_empty = frame_last && !buf_full_r;
    // disable takes effect only when nothing is left to send
    wire drained = shifter_idle && !buf_full_r;
    wire [8:0] wr_char = mask_char({ctrl_b_r[STX_B_NINTH_BIT],
                                    reg_wdata_in}, nbits);
    wire [7:0] stat_view = {1'b0, tx_complete_r, ~buf_full_r,
                            3'h0, stat_a_r[STX_A_DOUBLE_SPEED], 1'b0};
    wire [7:0] rd_mux = (reg_addr_in == STX_ADDR_STAT_A) ? stat_view :
                        (reg_addr_in == STX_ADDR_CTRL_B) ? ctrl_b_r :
                        (reg_addr_in == STX_ADDR_CTRL_C) ? ctrl_c_r :
                        (reg_addr_in == STX_ADDR_BAUD_LO) ? baud_r[7:0] :
                        (reg_addr_in == STX_ADDR_BAUD_HI) ?
                            {4'h0, baud_r[DIV_W-1:8]} : 8'h00;

    stx_bit_clock #(
        .DIV_W(DIV_W)
    ) u_bit_clock (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .divisor_in(baud_r),
        .double_speed_in(double_speed),
        .sync_mode_in(sync_mode),
        .clock_polarity_in(ctrl_c_r[STX_C_CLOCK_POL]),
        .clk_master_in(1'b1),
        .run_in(active_r),
        .sync_clock_pin_in(sync_clock_pin_in),
        .bit_strobe_out(bit_strobe),
        .sync_clock_out(sync_clk)
    );

    // frame sequencer
    always_comb
    begin
        state_nxt = state_r;
        if (bit_strobe)
        begin
            case (state_r)
                STX_IDLE:
                    if (load_shift)
                        state_nxt = STX_START;
                STX_START:
                    state_nxt = STX_DATA;
                STX_DATA:
                    if (bit_cnt_r == nbits - 4'h1)
                        state_nxt = parity_en ? STX_PARITY
                                              : STX_STOP;
                STX_PARITY:
                    state_nxt = STX_STOP;
                STX_STOP:
                    if (!two_stops || stop_cnt_r)
                        state_nxt = load_shift ? STX_START : STX_IDLE;
                default:
                    state_nxt = STX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state_r <= STX_IDLE;
        else
            state_r <= state_nxt;
    end

    // shifter, line level and parity
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            shift_r <= 9'h000;
            bit_cnt_r <= 4'h0;
            parity_r <= 1'b0;
            stop_cnt_r <= 1'b0;
            line_r <= 1'b1;
        end
        else if (bit_strobe)
        begin
            case (state_nxt)
                STX_START:
                begin
                    shift_r <= buf_data_r;
                    parity_r <= parity_odd;
                    line_r <= 1'b0;
                    bit_cnt_r <= 4'h0;
                end
                STX_DATA:
                begin
                    line_r <= shift_r[0];
                    parity_r <= parity_r ^ shift_r[0];
                    shift_r <= {1'b0, shift_r[8:1]};
                    bit_cnt_r <= (state_r == STX_DATA) ? bit_cnt_r + 4'h1
                                                       : 4'h0;
                end
                STX_PARITY:
                    line_r <= parity_r;
                STX_STOP:
                begin
                    line_r <= 1'b1;
                    stop_cnt_r <= (state_r == STX_STOP);
                end
                default:
                    line_r <= 1'b1;
            endcase
        end
    end

    // transmit buffer and flags
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            buf_data_r <= 9'h000;
            buf_full_r <= 1'b0;
            tx_complete_r <= 1'b0;
        end
        else
        begin
            if (wr_data)
            begin
                buf_data_r <= wr_char;
                buf_full_r <= 1'b1;
            end
            else if (load_shift)
                buf_full_r <= 1'b0;
            // set wins over either clear
            if (frame_done_empty)
                tx_complete_r <= 1'b1;
            else if (tx_complete_ack_in ||
                     (wr_stat && reg_wdata_in[STX_A_TX_COMPLETE]))
                tx_complete_r <= 1'b0;
        end
    end

    // configuration registers and enable drain
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            stat_a_r <= STX_RST_STAT_A;
            ctrl_b_r <= STX_RST_CTRL_B;
            ctrl_c_r <= STX_RST_CTRL_C;
            baud_r <= STX_RST_BAUD;
            active_r <= 1'b0;
        end
        else
        begin
            if (wr_stat)
                stat_a_r[STX_A_DOUBLE_SPEED] <=
                    reg_wdata_in[STX_A_DOUBLE_SPEED];
            if (wr_ctrl_b)
                ctrl_b_r <= reg_wdata_in;
            if (wr_ctrl_c)
                ctrl_c_r <= reg_wdata_in;
            if (wr_baud_lo)
                baud_r[7:0] <= reg_wdata_in;
            if (wr_baud_hi)
                baud_r[DIV_W-1:8] <= reg_wdata_in[DIV_W-9:0];
            if (tx_enable)
                active_r <= 1'b1;
            else if (drained)
                active_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rdata_r <= 8'h00;
        else if (reg_read_in)
            rdata_r <= rd_mux;
    end

    assign reg_rdata_out = rdata_r;
    assign buffer_empty_irq_out = ctrl_b_r[STX_B_BUF_EMPTY_IE] &
                                  ~buf_full_r;
    assign tx_complete_irq_out = ctrl_b_r[STX_B_TX_COMPLETE_IE] &
                                 tx_complete_r;
    assign serial_out = line_r;
    assign serial_oe_out = active_r;
    assign sync_clock_pin_out = sync_clk;
    // master clock drive while enabled in sync mode
    assign sync_clock_pin_oe_out = active_r & sync_mode;
endmodule

// ==== testbench/stx_transmitter_checker.sv ====
// port assertions for the serial transmitter
`timescale 1ns/1ns
module stx_transmitter_checker
    import stx_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // register port and service
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic tx_complete_ack_in,
    // outputs
    input wire logic buffer_empty_irq_out,
    input wire logic tx_complete_irq_out,
    input wire logic serial_out,
    input wire logic serial_oe_out
);
    wire dat_wr = reg_write_in && reg_addr_in == STX_ADDR_DATA;
    wire cb_wr = reg_write_in && reg_addr_in == STX_ADDR_CTRL_B;
    wire tc_wr = reg_write_in && reg_addr_in == STX_ADDR_STAT_A
        && reg_wdata_in[STX_A_TX_COMPLETE];
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    AST_DATA_WR_FILLS: assert property (dat_wr |=> !buffer_empty_irq_out)
        else $error("buffer empty after data write");
    AST_BE_IRQ_HOLDS: assert property (
        buffer_empty_irq_out && !dat_wr && !cb_wr |=> buffer_empty_irq_out)
        else $error("buffer empty request dropped");
    AST_TC_ACK_CLEARS: assert property (
        tx_complete_ack_in && tx_complete_irq_out |=> !tx_complete_irq_out)
        else $error("service did not clear complete");
    AST_TC_WR1_CLEARS: assert property (
        tc_wr && tx_complete_irq_out |=> !tx_complete_irq_out)
        else $error("write one did not clear complete");
    AST_TC_HOLDS: assert property (tx_complete_irq_out && !tx_complete_ack_in
        && !tc_wr && !cb_wr |=> tx_complete_irq_out)
        else $error("complete request dropped");
    AST_IDLE_HIGH: assert property (!serial_oe_out |-> serial_out)
        else $error("released line not high");
    AST_LOW_MIN: assert property ($fell(serial_out) |-> !serial_out [*8])
        else $error("low bit shorter than eight cycles");
    AST_HIGH_MIN: assert property ($rose(serial_out) |-> serial_out [*8])
        else $error("high bit shorter than eight cycles");
    AST_RELEASE_AFTER_STOP: assert property ($fell(serial_oe_out)
        |-> $past(serial_out, 4) && serial_out)
        else $error("pin released inside a frame");
    COV_FRAME: cover property ($fell(serial_out));
    COV_ACK: cover property (tx_complete_ack_in && tx_complete_irq_out);
    COV_RELEASE: cover property ($fell(serial_oe_out));
endmodule

bind stx_transmitter stx_transmitter_checker chk_u (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .tx_complete_ack_in(tx_complete_ack_in),
    .buffer_empty_irq_out(buffer_empty_irq_out),
    .tx_complete_irq_out(tx_complete_irq_out),
    .serial_out(serial_out), .serial_oe_out(serial_oe_out)
);

// ==== testbench/stx_rx_model.sv ====
// behavioural far-end receiver on the serial line
`timescale 1ns/1ns
module stx_rx_model
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // line and frame format
    input wire logic line_in,
    input wire logic oe_in,
    input wire logic [5:0] period_in,
    input wire logic [3:0] nbits_in,
    input wire logic par_en_in,
    input wire logic par_odd_in,
    input wire logic two_stop_in,
    // received character
    output logic valid_out,
    output logic [8:0] data_out,
    output logic bad_out
);
    logic [8:0] sh;
    logic bad;
    initial valid_out = 1'b0;
    // mid-bit sampling; a released line counts as a broken frame
    always
    begin
        @(posedge clk_in);
        if (rst_n_in === 1'b1 && oe_in === 1'b1 && line_in === 1'b0)
        begin
            repeat (period_in / 2) @(posedge clk_in);
            bad = line_in !== 1'b0;
            sh = 9'h000;
            for (int i = 0; i < nbits_in; i++)
            begin
                repeat (period_in) @(posedge clk_in);
                sh[i] = line_in;
            end
            if (par_en_in)
            begin
                repeat (period_in) @(posedge clk_in);
                bad = bad | (line_in !== (^sh ^ par_odd_in));
            end
            repeat (period_in) @(posedge clk_in);
            bad = bad | (line_in !== 1'b1) | (oe_in !== 1'b1);
            if (two_stop_in)
            begin
                repeat (period_in) @(posedge clk_in);
                bad = bad | (line_in !== 1'b1);
            end
            data_out <= sh;
            bad_out <= bad;
            valid_out <= 1'b1;
            @(posedge clk_in);
            valid_out <= 1'b0;
        end
    end
endmodule

// ==== testbench/stx_transmitter_tb.sv ====
// self-checking bench for the serial transmitter
`timescale 1ns/1ns
module stx_transmitter_tb
    import stx_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic tx_complete_ack_in = 1'b0;
    logic [7:0] reg_rdata_out, cb, rv;
    logic buffer_empty_irq_out, tx_complete_irq_out, serial_out, serial_oe_out;
    logic rx_valid, rx_bad, par_en, par_odd, two_stop, dbl, sync_oe;
    logic [8:0] rx_data;
    logic [5:0] period;
    logic [3:0] nbits;
    logic [2:0] sz;
    logic [31:0] seed = 32'h0000_001e;
    logic [8:0] exp_q[$];
    logic [6:0] cfg[5] = '{7'h30, 7'h0a, 7'h1d, 7'h23, 7'h7c};
    int err_count = 0;
    int checked = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    stx_transmitter dut_u (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out),
        .buffer_empty_irq_out(buffer_empty_irq_out),
        .tx_complete_irq_out(tx_complete_irq_out),
        .tx_complete_ack_in(tx_complete_ack_in),
        .serial_out(serial_out), .serial_oe_out(serial_oe_out),
        .sync_clock_pin_in(1'b0), .sync_clock_pin_out(),
        .sync_clock_pin_oe_out(sync_oe)
    );
    stx_rx_model rx_u (
        .clk_in(sys_clk_in), .rst_n_in(reset_n_in),
        .line_in(serial_out), .oe_in(serial_oe_out), .period_in(period),
        .nbits_in(nbits), .par_en_in(par_en), .par_odd_in(par_odd),
        .two_stop_in(two_stop), .valid_out(rx_valid),
        .data_out(rx_data), .bad_out(rx_bad)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic fail(input string m);
        err_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp)
            fail($sformatf("got %h want %h", got, exp));
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        #1 rv = reg_rdata_out;
    endtask
    // 0 buffer empty, 1 all frames out, 2 pin released
    task automatic wait_for(input int w);
        int n;
        n = 0;
        while (n < 4000 && !((w == 0 && buffer_empty_irq_out === 1'b1)
            || (w == 1 && exp_q.size() == 0 && tx_complete_irq_out === 1'b1)
            || (w == 2 && serial_oe_out === 1'b0)))
        begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        if (n == 4000)
            fail("wait timed out");
    endtask
    task automatic send();
        logic [31:0] r;
        r = xs();
        cb[STX_B_NINTH_BIT] = r[8];
        // request enable must be set before waiting on the request
        wr(STX_ADDR_CTRL_B, cb);
        wait_for(0);
        exp_q.push_back(r[8:0] & ((9'h001 << nbits) - 9'h001));
        wr(STX_ADDR_DATA, r[7:0]);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge sys_clk_in)
        if (rx_valid === 1'b1)
            chk({rx_bad, rx_data}, exp_q.size() ? {1'b0, exp_q.pop_front()}
                : {~rx_bad, rx_data});

    initial
    begin
        repeat (20) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        rd(STX_ADDR_STAT_A);
        chk({2'b00, rv}, {2'b00, STX_RST_STAT_A});
        chk({9'h000, serial_oe_out}, 10'h000);
        for (int k = 0; k < 5; k++)
        begin
            {sz, par_en, par_odd, two_stop, dbl} = cfg[k];
            nbits = (sz == 3'h7) ? 4'h9 : {1'b0, sz} + 4'h5;
            // first format runs at half rate to exercise the divisor
            period = (dbl ? 6'h08 : 6'h10) << (k == 0);
            wr(STX_ADDR_BAUD_LO, {7'h00, k == 0});
            wr(STX_ADDR_CTRL_C,
                {2'b00, par_en, par_odd, two_stop, sz[1:0], 1'b0});
            wr(STX_ADDR_STAT_A, {6'h00, dbl, 1'b0});
            cb = {4'h6, 1'b1, sz[2], 2'b00};
            send();
            send();
            rd(STX_ADDR_STAT_A);
            chk({2'b00, rv}, {8'h00, dbl, 1'b0});
            wait_for(1);
            rd(STX_ADDR_STAT_A);
            chk({2'b00, rv}, {5'h03, 3'h0, dbl, 1'b0});
            chk({9'h000, buffer_empty_irq_out}, 10'h001);
            if (k[0])
                wr(STX_ADDR_STAT_A, {6'h10, dbl, 1'b0});
            else
            begin
                @(posedge sys_clk_in);
                tx_complete_ack_in <= 1'b1;
                @(posedge sys_clk_in);
                tx_complete_ack_in <= 1'b0;
                #1;
            end
            chk({9'h000, tx_complete_irq_out}, 10'h000);
        end
        send();
        send();
        // asynchronous mode leaves the clock pin to the port
        chk({9'h000, sync_oe}, 10'h000);
        cb[STX_B_TX_ENABLE] = 1'b0;
        cb[STX_B_BUF_EMPTY_IE] = 1'b0;
        wr(STX_ADDR_CTRL_B, cb);
        chk({8'h00, serial_oe_out, buffer_empty_irq_out}, 10'h002);
        wait_for(2);
        chk(10'(exp_q.size()), 10'h000);
        chk({9'h000, serial_out}, 10'h001);
        stop_test();
    end

    initial
    begin
        repeat (40000) @(posedge sys_clk_in);
        fail("watchdog expired");
        stop_test();
    end
endmodule
